// ===== alc_consts.svh
// offsets, field positions, reset values and timing counts for alc_uart
`ifndef ALC_CONSTS_SVH
`define ALC_CONSTS_SVH
// register byte addresses
`define ALC_OFS_CTRL 4'h0
`define ALC_OFS_STAT 4'h4
`define ALC_OFS_TXD 4'h8
`define ALC_OFS_BAUD 4'hC
`define ALC_OFS_RXD 5'h10
// control fields
`define ALC_CTRL_LOOP 0
`define ALC_CTRL_RUN 1
// status fields
`define ALC_ST_TXRDY 0
`define ALC_ST_RXRDY 1
`define ALC_ST_PAR_FAULT 2
`define ALC_ST_FERR 3
`define ALC_ST_OVR 4
`define ALC_ST_RUN 5
`define ALC_ST_TXBUSY 6
// reset values
`define ALC_BAUD_RST 16'h0036
`define ALC_CTRL_RST 2'h0
// 16x clock: sixteen ticks per bit, half bit is eight
`define ALC_TICKS_PER_BIT 4'hF
`define ALC_HALF_BIT 4'h7
// axi responses
`define ALC_RESP_OK 2'h0
`define ALC_RESP_SLVERR 2'h2
`endif

// ===== alc_pkg.sv
// types shared by the async line controller
package alc_pkg;
  // character format as strapped by jumpers
  typedef struct packed {
    logic [1:0] nbits; // 0 = five data bits .. 3 = eight
    logic two_stop;
    logic par_en;
    logic par_odd;
  } alc_fmt_type;
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_PAR = 5'b01000,
    TX_STOP = 5'b10000
  } alc_tx_state_type;
  typedef enum logic [5:0] {
    RX_IDLE = 6'b000001,
    RX_START = 6'b000010,
    RX_DATA = 6'b000100,
    RX_PAR = 6'b001000,
    RX_STOP = 6'b010000,
    RX_BRK = 6'b100000
  } alc_rx_state_type;
  // one-hot register select
  typedef struct packed {
    logic ctrl;
    logic stat;
    logic txd;
    logic baud;
    logic rxd;
  } alc_sel_type;
endpackage

// ===== alc_term.sv
// serial terminal model that frames and reads characters on the line
`timescale 1ns/100ps
module alc_term #(
  parameter int BIT_CLKS = 32,
  parameter int WAIT_CLKS = 4000
) (
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_line
);
  // line idles at mark like a pulled-up loop
  initial o_line = 1'b1;

  task automatic hold(input logic b);
    o_line <= b;
  endtask

  task automatic put_bit(input logic b);
    o_line <= b;
    repeat (BIT_CLKS) @(posedge i_clk);
  endtask

  // start, data lsb first, parity, stops
  task automatic send(input alc_pkg::alc_fmt_type f, input logic [7:0] d,
                      input logic bad_par, input logic bad_stop);
    int i;
    @(posedge i_clk);
    put_bit(1'b0);
    for (i = 0; i < 5 + int'(f.nbits); i++) put_bit(d[i]);
    if (f.par_en) put_bit(^(d & (8'hFF >> (3 - int'(f.nbits))))
                          ^ f.par_odd ^ bad_par);
    put_bit(~bad_stop);
    if (f.two_stop) put_bit(1'b1);
    o_line <= 1'b1;
  endtask

  // samples at bit centres; ok low if no start edge came
  task automatic recv(input alc_pkg::alc_fmt_type f, output logic [7:0] d,
                      output logic p, output logic s, output logic ok);
    int i;
    d = 8'h00;
    p = 1'b0;
    for (i = 0; i < WAIT_CLKS && i_line !== 1'b0; i++) @(posedge i_clk);
    ok = (i_line === 1'b0);
    repeat (BIT_CLKS / 2) @(posedge i_clk);
    ok = ok && (i_line === 1'b0);
    for (i = 0; i < 5 + int'(f.nbits); i++) begin
      repeat (BIT_CLKS) @(posedge i_clk);
      d[i] = i_line;
    end
    if (f.par_en) begin
      repeat (BIT_CLKS) @(posedge i_clk);
      p = i_line;
    end
    repeat (BIT_CLKS) @(posedge i_clk);
    s = i_line;
    if (f.two_stop) begin
      repeat (BIT_CLKS) @(posedge i_clk);
      s = s & i_line;
    end
  endtask
endmodule // alc_term

// ===== alc_uart.sv
// async line controller: axi4-lite registers, 16x transmitter and receiver
// Functional notes
// - tx ready whenever holding buffer empty
// - buffer write makes load strobe into holding
// - pulse character done after stop bits
// - transmitter steps on its own 16x tick
// - five to eight data bits transmitted
// - start, data lsb first, parity, stops
// - line output driven from retiming flop
// - inverted copy of retimed output provided
// - retimed output always feeds loopback mux
// - loopback off passes external line through
// - input shift register decode clears reader-run
// - character ready flag after full character
// - parity fault flag readable by host
// - framing fault when stop bit low
// - overrun when character arrives unread
// - receiver steps on its own 16x tick
// - five to eight data bits received
// - format fixed by jumper pins only
// - receiver uses transmitter format settings
// - idle mark; start within one tick
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
`include "alc_consts.svh"
module alc_uart (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_AWVALID,
  input wire logic [4:0] I_AWADDR,
  output logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_WREADY,
  output logic O_BVALID,
  output logic [1:0] O_BRESP,
  input wire logic I_BREADY,
  input wire logic I_ARVALID,
  input wire logic [4:0] I_ARADDR,
  output logic O_ARREADY,
  output logic O_RVALID,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  input wire logic I_RREADY,
  input wire logic [4:0] I_FMT_JUMPERS,
  input wire logic I_SERIAL_IN,
  output logic O_SERIAL_OUT,
  output logic O_SERIAL_OUT_N,
  output logic O_TX_READY,
  output logic O_TX_CHAR_DONE
);
  // address decode shared by read and write paths
  function automatic alc_pkg::alc_sel_type addr_sel(input logic [4:0] a);
    alc_pkg::alc_sel_type s;
    s = '0;
    s.ctrl = (a == {1'b0, `ALC_OFS_CTRL});
    s.stat = (a == {1'b0, `ALC_OFS_STAT});
    s.txd = (a == {1'b0, `ALC_OFS_TXD});
    s.baud = (a == {1'b0, `ALC_OFS_BAUD});
    s.rxd = (a == `ALC_OFS_RXD);
    return s;
  endfunction

  // pin inputs pass two flops; jumpers are static but still off-domain
  logic [5:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_s1_q <= 6'h3F;
      pin_s2_q <= 6'h3F;
    end else begin
      pin_s1_q <= {I_SERIAL_IN, I_FMT_JUMPERS};
      pin_s2_q <= pin_s1_q;
    end
  end
  alc_pkg::alc_fmt_type fmt;
  logic si;
  logic rx_in; // conditioned input, after the loopback mux
  assign fmt = pin_s2_q[4:0];
  assign si = pin_s2_q[5];
  logic [2:0] last_bit;
  logic [7:0] dmask;
  assign last_bit = 3'h4 + {1'b0, fmt.nbits};
  assign dmask = 8'hFF >> (2'h3 - fmt.nbits);

  // registers written by software
  logic loop_q, run_q, bvalid_q, aw_full_q, w_full_q, awready_q, wready_q;
  logic [15:0] baud_q;
  logic [4:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  logic load_strobe, run_set, rd_clear;
  logic [1:0] rd_shift_q;
  alc_pkg::alc_sel_type wsel;
  assign wsel = addr_sel(awaddr_q);
  logic do_write;
  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign load_strobe = do_write && wsel.txd && wstrb_q[0];
  assign run_set = do_write && wsel.ctrl && wstrb_q[0] &&
                   wdata_q[`ALC_CTRL_RUN];

  // write channel: address and data latched separately, either order
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `ALC_RESP_OK;
      awaddr_q <= 5'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      awready_q <= I_AWVALID && !aw_full_q && !awready_q;
      wready_q <= I_WVALID && !w_full_q && !wready_q;
      if (I_AWVALID && awready_q) begin
        aw_full_q <= 1'b1;
        awaddr_q <= I_AWADDR;
      end
      if (I_WVALID && wready_q) begin
        w_full_q <= 1'b1;
        wdata_q <= I_WDATA;
        wstrb_q <= I_WSTRB;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wsel == '0) ? `ALC_RESP_SLVERR : `ALC_RESP_OK;
      end else if (bvalid_q && I_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // control bits; reader-run falls when the line drops to space
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      loop_q <= 1'b0;
      run_q <= 1'b0;
      baud_q <= `ALC_BAUD_RST;
      rd_shift_q <= 2'h3;
    end else begin
      rd_shift_q <= {rd_shift_q[0], rx_in};
      if (do_write && wsel.ctrl && wstrb_q[0]) begin
        loop_q <= wdata_q[`ALC_CTRL_LOOP];
      end
      if (do_write && wsel.baud) begin
        if (wstrb_q[0]) baud_q[7:0] <= wdata_q[7:0];
        if (wstrb_q[1]) baud_q[15:8] <= wdata_q[15:8];
      end
      if (run_set) begin
        run_q <= 1'b1; // set wins over the decode clear
      end else if (rd_shift_q == 2'b10) begin
        run_q <= 1'b0;
      end
    end
  end

  // two 16x tick dividers, one per direction, sharing the divisor
  logic [1:0] tick;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_div
      logic [15:0] cnt_q;
      always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
          cnt_q <= 16'h0000;
        end else begin
          cnt_q <= (cnt_q >= baud_q) ? 16'h0000 : cnt_q + 16'h0001;
        end
      end
      assign tick[g] = (cnt_q >= baud_q);
    end
  endgenerate
  logic tx_tick, rx_tick;
  assign tx_tick = tick[0];
  assign rx_tick = tick[1];

  // transmit holding buffer and serializer
  alc_pkg::alc_tx_state_type tx_st_q;
  logic [7:0] hold_q, tx_sh_q;
  logic hold_full_q, tx_line_q, tx_par_q, stop2_q, done_q, ser_n_q, rdy_q;
  logic [3:0] tx_sub_q;
  logic [2:0] tx_bit_q;
  logic tx_move;
  assign tx_move = tx_tick && tx_st_q == alc_pkg::TX_IDLE && hold_full_q;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      hold_q <= 8'h00;
      hold_full_q <= 1'b0;
    end else begin
      if (load_strobe) begin
        hold_q <= wdata_q[7:0] & dmask; // unused high bits are lost
        hold_full_q <= 1'b1; // set wins over the move
      end else if (tx_move) begin
        hold_full_q <= 1'b0;
      end
    end
  end
  // ready reflects an empty holding buffer
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdy_q <= 1'b1;
    end else begin
      rdy_q <= !hold_full_q && !load_strobe;
    end
  end
  // line only changes on a tick, so the retiming flop holds every bit
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tx_st_q <= alc_pkg::TX_IDLE;
      tx_line_q <= 1'b1;
      tx_sh_q <= 8'h00;
      tx_sub_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_par_q <= 1'b0;
      stop2_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (tx_tick) begin
        unique case (tx_st_q)
          alc_pkg::TX_IDLE: begin
            tx_sub_q <= 4'h0;
            if (hold_full_q) begin
              tx_sh_q <= hold_q;
              tx_par_q <= (^hold_q) ^ fmt.par_odd;
              tx_line_q <= 1'b0;
              tx_st_q <= alc_pkg::TX_START;
            end
          end
          alc_pkg::TX_START: begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == `ALC_TICKS_PER_BIT) begin
              tx_line_q <= tx_sh_q[0];
              tx_bit_q <= 3'h0;
              tx_st_q <= alc_pkg::TX_DATA;
            end
          end
          alc_pkg::TX_DATA: begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == `ALC_TICKS_PER_BIT) begin
              if (tx_bit_q == last_bit) begin
                tx_line_q <= fmt.par_en ? tx_par_q : 1'b1;
                stop2_q <= 1'b0;
                tx_st_q <= fmt.par_en ? alc_pkg::TX_PAR
                                      : alc_pkg::TX_STOP;
              end else begin
                tx_line_q <= tx_sh_q[1];
                tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                tx_bit_q <= tx_bit_q + 3'h1;
              end
            end
          end
          alc_pkg::TX_PAR: begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == `ALC_TICKS_PER_BIT) begin
              tx_line_q <= 1'b1;
              tx_st_q <= alc_pkg::TX_STOP;
            end
          end
          alc_pkg::TX_STOP: begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == `ALC_TICKS_PER_BIT) begin
              if (fmt.two_stop && !stop2_q) begin
                stop2_q <= 1'b1;
              end else begin
                done_q <= 1'b1;
                tx_st_q <= alc_pkg::TX_IDLE;
              end
            end
          end
        endcase
      end
    end
  end
  // inverted logic-level copy follows the retimed line by one clock
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ser_n_q <= 1'b0;
    end else begin
      ser_n_q <= !tx_line_q;
    end
  end

  // loopback mux: retimed output always reaches it
  assign rx_in = loop_q ? tx_line_q : si;

  // deserializer
  alc_pkg::alc_rx_state_type rx_st_q;
  logic [7:0] rx_sh_q;
  logic [3:0] rx_sub_q;
  logic [2:0] rx_bit_q;
  logic rx_acc_q, rx_pe_q, rx_fin_q, rx_fe_q;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rx_st_q <= alc_pkg::RX_IDLE;
      rx_sh_q <= 8'h00;
      rx_sub_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_acc_q <= 1'b0;
      rx_pe_q <= 1'b0;
      rx_fe_q <= 1'b0;
      rx_fin_q <= 1'b0;
    end else begin
      rx_fin_q <= 1'b0;
      if (rx_tick) begin
        rx_sub_q <= rx_sub_q + 4'h1;
        unique case (rx_st_q)
          alc_pkg::RX_IDLE: begin
            rx_sub_q <= 4'h0;
            if (!rx_in) rx_st_q <= alc_pkg::RX_START;
          end
          // a start shorter than half a bit is rejected
          alc_pkg::RX_START: begin
            if (rx_sub_q == `ALC_HALF_BIT) begin
              rx_sub_q <= 4'h0;
              rx_bit_q <= 3'h0;
              rx_sh_q <= 8'h00;
              rx_acc_q <= fmt.par_odd;
              rx_pe_q <= 1'b0;
              rx_st_q <= rx_in ? alc_pkg::RX_IDLE : alc_pkg::RX_DATA;
            end
          end
          alc_pkg::RX_DATA: begin
            if (rx_sub_q == `ALC_TICKS_PER_BIT) begin
              rx_sh_q[rx_bit_q] <= rx_in; // lsb first
              rx_acc_q <= rx_acc_q ^ rx_in;
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == last_bit) begin
                rx_st_q <= fmt.par_en ? alc_pkg::RX_PAR
                                      : alc_pkg::RX_STOP;
              end
            end
          end
          alc_pkg::RX_PAR: begin
            if (rx_sub_q == `ALC_TICKS_PER_BIT) begin
              rx_pe_q <= rx_acc_q ^ rx_in;
              rx_st_q <= alc_pkg::RX_STOP;
            end
          end
          alc_pkg::RX_STOP: begin
            if (rx_sub_q == `ALC_TICKS_PER_BIT) begin
              rx_fin_q <= 1'b1;
              rx_fe_q <= !rx_in;
              // a held space must go back to mark before the next start
              rx_st_q <= rx_in ? alc_pkg::RX_IDLE : alc_pkg::RX_BRK;
            end
          end
          alc_pkg::RX_BRK: begin
            if (rx_in) rx_st_q <= alc_pkg::RX_IDLE;
          end
        endcase
      end
    end
  end

  // host-visible receive status, updated per character
  logic rx_rdy_q, rx_ovr_q, rx_parf_q, rx_ferr_q;
  logic [7:0] rx_data_q;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rx_rdy_q <= 1'b0;
      rx_ovr_q <= 1'b0;
      rx_parf_q <= 1'b0;
      rx_ferr_q <= 1'b0;
      rx_data_q <= 8'h00;
    end else begin
      if (rx_fin_q) begin
        rx_rdy_q <= 1'b1; // set wins over the read clear
        rx_ovr_q <= rx_rdy_q && !rd_clear;
        rx_parf_q <= rx_pe_q && fmt.par_en;
        rx_ferr_q <= rx_fe_q;
        rx_data_q <= rx_sh_q;
      end else if (rd_clear) begin
        rx_rdy_q <= 1'b0;
      end
    end
  end

  // read channel
  logic arready_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  alc_pkg::alc_sel_type rsel;
  assign rsel = addr_sel(I_ARADDR);
  assign rd_clear = I_ARVALID && arready_q && rsel.rxd;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `ALC_RESP_OK;
    end else begin
      arready_q <= I_ARVALID && !arready_q && !rvalid_q;
      if (I_ARVALID && arready_q) begin
        rvalid_q <= 1'b1;
        rresp_q <= (rsel == '0) ? `ALC_RESP_SLVERR : `ALC_RESP_OK;
        rdata_q <= 32'h0000_0000;
        if (rsel.ctrl) rdata_q[1:0] <= {run_q, loop_q};
        if (rsel.stat) rdata_q[6:0] <= {tx_st_q != alc_pkg::TX_IDLE, run_q,
          rx_ovr_q, rx_ferr_q, rx_parf_q, rx_rdy_q, rdy_q};
        if (rsel.baud) rdata_q[15:0] <= baud_q;
        if (rsel.rxd) rdata_q[7:0] <= rx_data_q;
      end else if (rvalid_q && I_RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign O_AWREADY = awready_q;
  assign O_WREADY = wready_q;
  assign O_BVALID = bvalid_q;
  assign O_BRESP = bresp_q;
  assign O_ARREADY = arready_q;
  assign O_RVALID = rvalid_q;
  assign O_RDATA = rdata_q;
  assign O_RRESP = rresp_q;
  assign O_SERIAL_OUT = tx_line_q;
  assign O_SERIAL_OUT_N = ser_n_q;
  assign O_TX_READY = rdy_q;
  assign O_TX_CHAR_DONE = done_q;

  // checks next to the logic they guard
  property p_rdy_low;
    @(posedge I_CLK) disable iff (!I_RST_N) hold_full_q |=> !O_TX_READY;
  endproperty
  a_rdy_low: assert property (p_rdy_low)
    else $error("ready while full");
  property p_load;
    @(posedge I_CLK) disable iff (!I_RST_N)
      load_strobe |=> hold_full_q && hold_q == ($past(wdata_q[7:0]) & dmask);
  endproperty
  a_load: assert property (p_load) else $error("load not captured");
  property p_done_mark;
    @(posedge I_CLK) disable iff (!I_RST_N)
      O_TX_CHAR_DONE |-> O_SERIAL_OUT && tx_st_q == alc_pkg::TX_IDLE;
  endproperty
  a_done_mark: assert property (p_done_mark)
    else $error("done not idle");
  property p_tx_tick;
    @(posedge I_CLK) disable iff (!I_RST_N) !tx_tick |=> $stable(tx_line_q);
  endproperty
  a_tx_tick: assert property (p_tx_tick) else $error("line off tick");
  property p_start;
    @(posedge I_CLK) disable iff (!I_RST_N) tx_move |=> !O_SERIAL_OUT;
  endproperty
  a_start: assert property (p_start) else $error("start bit late");
  property p_inv;
    @(posedge I_CLK) disable iff (!I_RST_N)
      ##1 1'b1 |-> O_SERIAL_OUT_N == !$past(O_SERIAL_OUT);
  endproperty
  a_inv: assert property (p_inv) else $error("inverted copy wrong");
  property p_loop;
    @(posedge I_CLK) disable iff (!I_RST_N)
      loop_q && rx_tick && rx_st_q == alc_pkg::RX_IDLE && !tx_line_q
      |=> rx_st_q == alc_pkg::RX_START;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback not seen");
  property p_ovr;
    @(posedge I_CLK) disable iff (!I_RST_N)
      rx_fin_q && rx_rdy_q && !rd_clear |=> rx_ovr_q && rx_rdy_q;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun missed");
  property p_run;
    @(posedge I_CLK) disable iff (!I_RST_N)
      rd_shift_q == 2'b10 && !run_set |=> !run_q;
  endproperty
  a_run: assert property (p_run) else $error("reader run kept");
endmodule // alc_uart

// ===== tb_top.sv
// self-checking bench for the async line controller
`timescale 1ns/100ps
`include "alc_consts.svh"
module tb_top;
  localparam int BAUD_VAL = 1;
  localparam int BIT = 16 * (BAUD_VAL + 1);
  logic I_CLK, I_RST_N, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
  logic [4:0] I_AWADDR, I_ARADDR, I_FMT_JUMPERS;
  logic [31:0] I_WDATA, O_RDATA;
  logic [3:0] I_WSTRB;
  logic [1:0] O_BRESP, O_RRESP;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  logic O_SERIAL_OUT, O_SERIAL_OUT_N, O_TX_READY, O_TX_CHAR_DONE, out_q;
  wire logic I_SERIAL_IN;
  int error_cnt, cmp_count, done_cnt;

  alc_uart alc_uart_inst (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
    .I_AWVALID(I_AWVALID), .I_AWADDR(I_AWADDR),
    .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .I_WDATA(I_WDATA),
    .I_WSTRB(I_WSTRB), .O_WREADY(O_WREADY), .O_BVALID(O_BVALID),
    .O_BRESP(O_BRESP), .I_BREADY(I_BREADY), .I_ARVALID(I_ARVALID),
    .I_ARADDR(I_ARADDR), .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID),
    .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .I_RREADY(I_RREADY),
    .I_FMT_JUMPERS(I_FMT_JUMPERS), .I_SERIAL_IN(I_SERIAL_IN),
    .O_SERIAL_OUT(O_SERIAL_OUT), .O_SERIAL_OUT_N(O_SERIAL_OUT_N),
    .O_TX_READY(O_TX_READY), .O_TX_CHAR_DONE(O_TX_CHAR_DONE));
  alc_term #(.BIT_CLKS(BIT)) alc_term_inst (.i_clk(I_CLK),
    .i_line(O_SERIAL_OUT), .o_line(I_SERIAL_IN));

  initial begin
    I_CLK = 1'b0;
    forever #5 I_CLK = ~I_CLK;
  end

  // inverted copy trails the line by one clock
  always @(posedge I_CLK) begin
    if (I_RST_N === 1'b1 && O_SERIAL_OUT_N !== ~out_q) begin
      $display("wrong value serial_out_n exp %b got %b", ~out_q,
               O_SERIAL_OUT_N);
      error_cnt++;
    end
    out_q = O_SERIAL_OUT;
    if (O_TX_CHAR_DONE === 1'b1) done_cnt++;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s exp %h got %h", nm, e, g);
      error_cnt++;
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic hang(input string nm);
    $display("wrong value %s exp answer got timeout", nm);
    error_cnt++;
    report_and_stop();
  endtask

  // master offers address and data together, waits for the response
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d,
                           input logic [1:0] er);
    int n;
    I_AWADDR <= a;
    I_WDATA <= d;
    I_WSTRB <= 4'hF;
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    I_BREADY <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge I_CLK);
      if (I_AWVALID && O_AWREADY === 1'b1) I_AWVALID <= 1'b0;
      if (I_WVALID && O_WREADY === 1'b1) I_WVALID <= 1'b0;
      if (O_BVALID === 1'b1) break;
    end
    if (n == 100) hang("bvalid");
    chk("bresp", er, O_BRESP);
    I_BREADY <= 1'b0;
    @(posedge I_CLK);
  endtask

  task automatic axi_read(input logic [4:0] a, output logic [31:0] d,
                          input logic [1:0] er);
    int n;
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    I_RREADY <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge I_CLK);
      if (I_ARVALID && O_ARREADY === 1'b1) I_ARVALID <= 1'b0;
      if (O_RVALID === 1'b1) break;
    end
    if (n == 100) hang("rvalid");
    d = O_RDATA;
    chk("rresp", er, O_RRESP);
    I_RREADY <= 1'b0;
    @(posedge I_CLK);
  endtask

  // polls status until a character waits; bounded by read count
  task automatic wait_rx(output logic [31:0] v);
    int n;
    for (n = 0; n < 300; n++) begin
      axi_read(`ALC_OFS_STAT, v, `ALC_RESP_OK);
      if (v[`ALC_ST_RXRDY] === 1'b1) break;
    end
    if (n == 300) hang("rx ready");
  endtask

  task automatic run_fmt(input alc_pkg::alc_fmt_type f);
    logic [31:0] v;
    logic [7:0] d, m;
    logic p, s, ok;
    int n;
    m = 8'hFF >> (3 - int'(f.nbits));
    // straps pass the two pin flops after reset is released
    I_FMT_JUMPERS <= f;
    I_RST_N <= 1'b0;
    repeat (3) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    repeat (3) @(posedge I_CLK);
    done_cnt = 0;
    chk("tx_ready", 1, O_TX_READY);
    chk("line idle", 1, O_SERIAL_OUT);
    axi_read(`ALC_OFS_STAT, v, `ALC_RESP_OK);
    chk("status", 32'h0000_0001, v);
    axi_read(`ALC_OFS_BAUD, v, `ALC_RESP_OK);
    chk("baud", 32'h0000_0036, v);
    axi_read(5'h14, v, `ALC_RESP_SLVERR);
    chk("unmapped", 32'h0000_0000, v);
    axi_write(`ALC_OFS_BAUD, BAUD_VAL, `ALC_RESP_OK);
    $display("test reset values done");
    // two characters back to back fill holding behind the shifter
    fork
      begin
        alc_term_inst.recv(f, d, p, s, ok);
        chk("tx char0", 8'hA5 & m, d & {8{ok}});
        chk("tx par0", f.par_en & (^(8'hA5 & m) ^ f.par_odd), p);
        chk("tx stop0", 1, s);
        alc_term_inst.recv(f, d, p, s, ok);
        chk("tx char1", 8'h3C & m, d & {8{ok}});
        chk("tx par1", f.par_en & (^(8'h3C & m) ^ f.par_odd), p);
        chk("tx stop1", 1, s);
      end
      begin
        axi_write(`ALC_OFS_TXD, 32'h0000_00A5, `ALC_RESP_OK);
        for (n = 0; n < 6 && O_SERIAL_OUT !== 1'b0; n++) @(posedge I_CLK);
        chk("start soon", 0, O_SERIAL_OUT);
        axi_write(`ALC_OFS_TXD, 32'h0000_003C, `ALC_RESP_OK);
        repeat (2) @(posedge I_CLK);
        chk("holding full", 0, O_TX_READY);
      end
    join
    repeat (2 * BIT) @(posedge I_CLK);
    chk("char done", 2, done_cnt);
    chk("tx empty", 1, O_TX_READY);
    $display("test transmit done");
    // good, bad parity, bad stop, then overrun and recovery
    alc_term_inst.send(f, 8'h5A, 1'b0, 1'b0);
    wait_rx(v);
    chk("rx status", 32'h0000_0003, v);
    axi_read(`ALC_OFS_RXD, v, `ALC_RESP_OK);
    chk("rx data", 8'h5A & m, v);
    axi_read(`ALC_OFS_STAT, v, `ALC_RESP_OK);
    chk("rx read clears", 32'h0000_0001, v);
    alc_term_inst.send(f, 8'h33, 1'b1, 1'b0);
    wait_rx(v);
    chk("parity fault", f.par_en, v[`ALC_ST_PAR_FAULT]);
    chk("no stop fault", 0, v[`ALC_ST_FERR]);
    axi_read(`ALC_OFS_RXD, v, `ALC_RESP_OK);
    alc_term_inst.send(f, 8'h0F, 1'b0, 1'b1);
    wait_rx(v);
    chk("stop fault", 1, v[`ALC_ST_FERR]);
    axi_read(`ALC_OFS_RXD, v, `ALC_RESP_OK);
    alc_term_inst.send(f, 8'h11, 1'b0, 1'b0);
    alc_term_inst.send(f, 8'h22, 1'b0, 1'b0);
    wait_rx(v);
    chk("overrun", 1, v[`ALC_ST_OVR]);
    axi_read(`ALC_OFS_RXD, v, `ALC_RESP_OK);
    alc_term_inst.send(f, 8'h44, 1'b0, 1'b0);
    wait_rx(v);
    chk("flags renewed", 32'h0000_0003, v);
    axi_read(`ALC_OFS_RXD, v, `ALC_RESP_OK);
    $display("test receive done");
    // reader-run set by software, cleared by a start edge
    axi_write(`ALC_OFS_CTRL, 32'h0000_0002, `ALC_RESP_OK);
    axi_read(`ALC_OFS_STAT, v, `ALC_RESP_OK);
    chk("run set", 1, v[`ALC_ST_RUN]);
    alc_term_inst.send(f, 8'h66, 1'b0, 1'b0);
    wait_rx(v);
    chk("run cleared", 0, v[`ALC_ST_RUN]);
    axi_read(`ALC_OFS_RXD, v, `ALC_RESP_OK);
    // loopback with the outside line stuck at space
    axi_write(`ALC_OFS_CTRL, 32'h0000_0001, `ALC_RESP_OK);
    axi_read(`ALC_OFS_CTRL, v, `ALC_RESP_OK);
    chk("ctrl", 32'h0000_0001, v);
    alc_term_inst.hold(1'b0);
    axi_write(`ALC_OFS_TXD, 32'h0000_00C3, `ALC_RESP_OK);
    wait_rx(v);
    chk("loop flags", 32'h0000_0002, v & 32'h0000_001E);
    axi_read(`ALC_OFS_RXD, v, `ALC_RESP_OK);
    chk("loop data", 8'hC3 & m, v);
    alc_term_inst.hold(1'b1);
    $display("test loopback done");
  endtask

  // hang guard for the whole run
  initial begin
    repeat (100000) @(posedge I_CLK);
    hang("run length");
  end

  initial begin
    I_RST_N = 1'b0;
    I_AWVALID = 1'b0;
    I_WVALID = 1'b0;
    I_BREADY = 1'b0;
    I_ARVALID = 1'b0;
    I_RREADY = 1'b0;
    I_AWADDR = 5'h00;
    I_ARADDR = 5'h00;
    I_WDATA = 32'h0000_0000;
    I_WSTRB = 4'h0;
    I_FMT_JUMPERS = 5'h1A;
    out_q = 1'b1;
    error_cnt = 0;
    cmp_count = 0;
    @(posedge I_CLK);
    run_fmt(5'h1A);
    run_fmt(5'h07);
    run_fmt(5'h08);
    report_and_stop();
  end
endmodule // tb_top
